// ===== shared/dzq_pkg.sv
// Shared constants and types for the ZQ calibration sequencing ends.
// Assumes a single 100 MHz clock; intervals are counted in clock cycles.
package dzq_pkg;

   // ------------------------------------------------------------------
   // Timing figures
   // ------------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 10;
   // Intervals in DRAM clock cycles or ns, as DDR3 counts them
   localparam int T_ZQINIT_NCK    = 512;
   localparam int T_ZQOPER_NCK    = 256;
   localparam int T_ZQCS_NCK      = 64;
   localparam int T_RP_NS         = 14;
   localparam int T_XS_NS         = 270;
   localparam int T_RP_CYC        = (T_RP_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int T_XS_CYC        = (T_XS_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam int CNT_W           = 12;

   // ------------------------------------------------------------------
   // Command encoding on the link
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      DZQ_CMD_NOP  = 3'h0,
      DZQ_CMD_ZQCL = 3'h1,
      DZQ_CMD_ZQCS = 3'h2,
      DZQ_CMD_PREA = 3'h3,
      DZQ_CMD_SRE  = 3'h4,
      DZQ_CMD_SRX  = 3'h5,
      DZQ_CMD_OTH  = 3'h6
   } dzq_cmd_e;

endpackage : dzq_pkg

// ===== shared/dzq_link_if.sv
// Link between the memory controller end and the DRAM end.
// Assumes both ends run on mclk; the DQ wire level is resolved here.
`timescale 1ns/1ns
interface dzq_link_if;
   logic           mclk;
   logic           sys_rst;
   logic [2:0]     cmd;
   logic           cke;
   logic           odt;
   logic           dq_ctl_oe;
   logic           dq_dev_oe;
   logic           dq_wire_busy;

   assign dq_wire_busy = dq_ctl_oe | dq_dev_oe;

   modport ctl (
      input  mclk,
      input  sys_rst,
      output cmd,
      output cke,
      output odt,
      output dq_ctl_oe
   );

   modport dev (
      input  mclk,
      input  sys_rst,
      input  cmd,
      input  cke,
      input  odt,
      output dq_dev_oe
   );
endinterface : dzq_link_if

// ===== logic/dzq_timer.sv
// Down-counter that marks the end of a loaded interval.
// Assumes load and count come from logic on the same clock.
`timescale 1ns/1ns
module dzq_timer #(
   parameter int W = 12
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         sys_rst,
   // Control
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   // Status
   output logic              busy,
   output logic              done
);
   logic [W-1:0] cnt_q;
   logic         done_q;

   assign busy = (cnt_q != '0);
   assign done = done_q;

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         cnt_q  <= '0;
         done_q <= 1'b0;
      end
      else if (load)
      begin
         cnt_q  <= value;
         done_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= busy ? cnt_q - W'(1) : cnt_q;
         done_q <= (cnt_q == W'(1));
      end
   end
endmodule : dzq_timer

// ===== logic/dzq_dev.sv
// DRAM end: ZQ calibration engine, result transfer and ZQ path power.
// Assumes the controller keeps the channel quiet while calibration runs.
`timescale 1ns/1ns
module dzq_dev (
   // Link
   dzq_link_if.dev        lnk,
   // User side
   output logic           cal_busy,
   output logic           zq_path_on,
   output logic           io_updated,
   output logic [7:0]     io_cal_count,
   output logic           in_self_refresh
);
   logic       first_q, zq_on_q, upd_q, sr_q;
   logic [7:0] count_q;
   logic       load, t_done;
   logic [dzq_pkg::CNT_W-1:0] len;

   // Command comes from a register on the same clock: no synchroniser
   wire is_zqcl = (lnk.cmd == dzq_pkg::DZQ_CMD_ZQCL);
   wire is_zqcs = (lnk.cmd == dzq_pkg::DZQ_CMD_ZQCS);
   wire is_sre  = (lnk.cmd == dzq_pkg::DZQ_CMD_SRE);
   wire is_srx  = (lnk.cmd == dzq_pkg::DZQ_CMD_SRX);
   // Any calibration command restarts the engine, except while in self refresh
   assign load = (is_zqcl | is_zqcs) & ~sr_q;
   assign len  = is_zqcs ? dzq_pkg::CNT_W'(dzq_pkg::T_ZQCS_NCK)
               : first_q ? dzq_pkg::CNT_W'(dzq_pkg::T_ZQINIT_NCK)
               : dzq_pkg::CNT_W'(dzq_pkg::T_ZQOPER_NCK);

   dzq_timer #(.W(dzq_pkg::CNT_W)) u_tmr (
      .mclk    (lnk.mclk),
      .sys_rst (lnk.sys_rst),
      .load    (load),
      .value   (len),
      .busy    (),
      .done    (t_done)
   );

   assign lnk.dq_dev_oe   = 1'b0;
   assign cal_busy        = zq_on_q;
   assign zq_path_on      = zq_on_q;
   assign io_updated      = upd_q;
   assign io_cal_count    = count_q;
   assign in_self_refresh = sr_q;

   always_ff @(posedge lnk.mclk)
   begin
      if (lnk.sys_rst)
      begin
         first_q <= 1'b1;
         zq_on_q <= 1'b0;
         upd_q   <= 1'b0;
         sr_q    <= 1'b0;
         count_q <= 8'h00;
      end
      else
      begin
         if (load && is_zqcl)
            first_q <= 1'b0;
         // Path on while engine runs, off once it is done
         zq_on_q <= load | (zq_on_q & ~t_done);
         upd_q   <= t_done;
         if (t_done)
            count_q <= count_q + 8'h01;
         // Self refresh exit never starts calibration by itself
         if (is_sre)
            sr_q <= 1'b1;
         else if (is_srx)
            sr_q <= 1'b0;
      end
   end
endmodule : dzq_dev

// ===== logic/dzq_ctl.sv
// Controller end: sequences ZQ calibration commands onto the link.
// Assumes one rank per link; ranks sharing a resistor need other logic to
// keep their intervals apart, as this controller drives a single link.
`timescale 1ns/1ns
module dzq_ctl (
   // Link
   dzq_link_if.ctl        lnk,
   // User request
   input  wire logic      req_valid,
   input  wire logic      req_long,
   output logic           req_ready,
   // Self refresh control
   input  wire logic      sr_enter,
   input  wire logic      sr_exit,
   // Status
   output logic           cal_active,
   output logic           cal_done,
   output logic           init_done
);
   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef enum logic [4:0] {
      S_IDLE = 5'h01,
      S_PRE  = 5'h02,
      S_TRP  = 5'h04,
      S_CAL  = 5'h08,
      S_SR   = 5'h10
   } dzq_ctl_state_e;

   dzq_ctl_state_e st_q, st_d;
   logic           first_q, long_q, done_q, init_q, cke_q, odt_q;
   logic           ready_q, act_q;
   logic [2:0]     cmd_q, cmd_d;
   logic [8:0]     xs_q;
   logic           load, t_done;
   logic [dzq_pkg::CNT_W-1:0] len;

   wire xs_ok = (xs_q == 9'h000);
   wire take  = (st_q == S_IDLE) & req_valid & xs_ok;
   wire go_sr = (st_q == S_IDLE) & sr_enter & ~req_valid;
   // Ready next cycle: idle and the tXS count run out by then
   wire ready_d = (st_d == S_IDLE) & ~((st_q == S_SR) & sr_exit)
                & (xs_q <= 9'h001);

   // ------------------------------------------------------------------
   // Interval selection
   // ------------------------------------------------------------------
   assign len = (st_q == S_PRE) ? dzq_pkg::CNT_W'(dzq_pkg::T_RP_CYC)
              : !long_q ? dzq_pkg::CNT_W'(dzq_pkg::T_ZQCS_NCK)
              : first_q ? dzq_pkg::CNT_W'(dzq_pkg::T_ZQINIT_NCK)
              : dzq_pkg::CNT_W'(dzq_pkg::T_ZQOPER_NCK);
   assign load = (st_q == S_PRE) | (st_q == S_TRP & t_done);

   dzq_timer #(.W(dzq_pkg::CNT_W)) u_tmr (
      .mclk    (lnk.mclk),
      .sys_rst (lnk.sys_rst),
      .load    (load),
      .value   (len),
      .busy    (),
      .done    (t_done)
   );

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb
   begin
      st_d  = st_q;
      cmd_d = dzq_pkg::DZQ_CMD_NOP;
      unique case (st_q)
         S_IDLE:
         begin
            if (take)
            begin
               st_d  = S_PRE;
               cmd_d = dzq_pkg::DZQ_CMD_PREA;
            end
            else if (go_sr)
            begin
               st_d  = S_SR;
               cmd_d = dzq_pkg::DZQ_CMD_SRE;
            end
         end
         S_PRE:
            st_d = S_TRP;
         S_TRP:
         begin
            if (t_done)
            begin
               st_d  = S_CAL;
               cmd_d = long_q ? dzq_pkg::DZQ_CMD_ZQCL
                              : dzq_pkg::DZQ_CMD_ZQCS;
            end
         end
         S_CAL:
         begin
            if (t_done)
               st_d = S_IDLE;
         end
         S_SR:
         begin
            if (sr_exit)
            begin
               st_d  = S_IDLE;
               cmd_d = dzq_pkg::DZQ_CMD_SRX;
            end
         end
      endcase
   end

   assign req_ready     = ready_q;
   assign cal_active    = act_q;
   assign cal_done      = done_q;
   assign init_done     = init_q;
   assign lnk.cmd       = cmd_q;
   assign lnk.cke       = cke_q;
   assign lnk.odt       = odt_q;
   assign lnk.dq_ctl_oe = 1'b0;

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge lnk.mclk)
   begin
      if (lnk.sys_rst)
      begin
         st_q    <= S_IDLE;
         cmd_q   <= 3'h0;
         first_q <= 1'b1;
         long_q  <= 1'b1;
         done_q  <= 1'b0;
         init_q  <= 1'b0;
         cke_q   <= 1'b1;
         odt_q   <= 1'b0;
         xs_q    <= 9'h000;
         ready_q <= 1'b1;
         act_q   <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         cmd_q  <= cmd_d;
         ready_q <= ready_d;
         act_q  <= (st_d == S_CAL);
         done_q <= (st_q == S_CAL) & t_done;
         // First request after reset is forced long
         if (take)
            long_q <= req_long | first_q;
         if (st_q == S_CAL && t_done && long_q)
         begin
            first_q <= 1'b0;
            init_q  <= 1'b1;
         end
         cke_q <= (st_d != S_SR);
         odt_q <= 1'b0;
         if (st_q == S_SR && sr_exit)
            xs_q <= 9'(dzq_pkg::T_XS_CYC);
         else if (!xs_ok)
            xs_q <= xs_q - 9'h001;
      end
   end
endmodule : dzq_ctl

// ===== tb/dzq_link_chk.sv
// Checker for the calibration link between the two ends.
// Assumes it is instantiated beside the link, on its clock and reset.
`timescale 1ns/1ns
module dzq_link_chk (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       sys_rst,
   // Link
   input wire logic [2:0] cmd,
   input wire logic       cke,
   input wire logic       odt,
   input wire logic       dq_wire_busy
);
   logic [11:0] quiet_q;
   logic        long_q;
   logic [11:0] xs_q;
   wire logic   zql = (cmd == dzq_pkg::DZQ_CMD_ZQCL);
   wire logic   zqs = (cmd == dzq_pkg::DZQ_CMD_ZQCS);
   wire logic   zq = zql | zqs;
   wire logic   nop = (cmd == dzq_pkg::DZQ_CMD_NOP);
   wire logic [11:0] ld = long_q ? 12'(dzq_pkg::T_ZQOPER_NCK - 1)
                                 : 12'(dzq_pkg::T_ZQINIT_NCK - 1);
   // Quiet window left, first long seen, cycles since self refresh exit
   always_ff @(posedge mclk)
   begin
      if (sys_rst)
      begin
         quiet_q <= 12'h000;
         long_q  <= 1'b0;
         xs_q    <= 12'hFFF;
      end
      else
      begin
         quiet_q <= zql ? ld : zqs ? 12'(dzq_pkg::T_ZQCS_NCK - 1)
                    : quiet_q - 12'(quiet_q != 12'h000);
         long_q  <= long_q | zql;
         xs_q    <= (cmd == dzq_pkg::DZQ_CMD_SRX) ? 12'h000
                    : xs_q + 12'(xs_q != 12'hFFF);
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_odt_held_off: assert property (!odt)
      else $error("odt driven during operation");
   a_dq_high_z: assert property (!dq_wire_busy)
      else $error("dq driven");
   a_channel_quiet: assert property (quiet_q != 12'h000 |-> nop)
      else $error("command inside calibration window");
   a_cke_during_cal: assert property (quiet_q != 12'h000 |-> cke)
      else $error("cke low inside calibration window");
   a_zq_after_prea: assert property (zq |-> $past(nop, 1) && $past(nop, 2)
      && ($past(cmd, 3) == dzq_pkg::DZQ_CMD_PREA
      || $past(cmd, 4) == dzq_pkg::DZQ_CMD_PREA))
      else $error("zq command without precharge and tRP");
   a_first_is_long: assert property (zqs |-> long_q)
      else $error("short calibration before first long one");
   a_txs_before_zq: assert property (zq |-> xs_q >= dzq_pkg::T_XS_CYC - 1)
      else $error("zq command inside tXS");
   a_zq_with_cke: assert property (zq |-> cke && $past(cke))
      else $error("zq command without cke high");
endmodule : dzq_link_chk

// ===== tb/dzq_bench.sv
// Bench joining controller and DRAM ends over the link.
// Assumes the full package timing counts; one 100 MHz clock.
`timescale 1ns/1ns
module dzq_bench;
   logic       mclk;
   logic       sys_rst;
   logic       req_valid;
   logic       req_long;
   logic       sr_enter;
   logic       sr_exit;
   logic       req_ready;
   logic       cal_active;
   logic       cal_done;
   logic       init_done;
   logic       cal_busy;
   logic       zq_path_on;
   logic       io_updated;
   logic       in_self_refresh;
   logic [7:0] io_cal_count;
   logic [7:0] n_cal;
   int         n_errors;
   int         compares;
   dzq_link_if lnk ();
   assign lnk.mclk = mclk;
   assign lnk.sys_rst = sys_rst;
   dzq_ctl u_dzq_ctl (.lnk(lnk.ctl), .req_valid(req_valid),
      .req_long(req_long), .req_ready(req_ready), .sr_enter(sr_enter),
      .sr_exit(sr_exit), .cal_active(cal_active), .cal_done(cal_done),
      .init_done(init_done));
   dzq_dev u_dzq_dev (.lnk(lnk.dev), .cal_busy(cal_busy),
      .zq_path_on(zq_path_on), .io_updated(io_updated),
      .io_cal_count(io_cal_count), .in_self_refresh(in_self_refresh));
   dzq_link_chk u_dzq_link_chk (.mclk(lnk.mclk), .sys_rst(lnk.sys_rst),
      .cmd(lnk.cmd), .cke(lnk.cke), .odt(lnk.odt),
      .dq_wire_busy(lnk.dq_wire_busy));
   always #5 mclk = ~mclk;
   task chk(input string what, input logic [11:0] e, input logic [11:0] g);
      compares++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected %s: expected %0h seen %0h", what, e, g);
      end
   endtask : chk
   task end_sim;
      $display("compares %0d, n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   task do_reset(input int n);
      @(posedge mclk) sys_rst <= 1'b1;
      repeat (n) @(posedge mclk);
      sys_rst <= 1'b0;
      n_cal = 8'h00;
      @(negedge mclk);
      chk("req_ready", 12'h001, req_ready);
      chk("init_done", 12'h000, init_done);
      chk("cke", 12'h001, lnk.cke);
      chk("io_cal_count", 12'h000, io_cal_count);
      $display("reset test done");
   endtask : do_reset
   task cal(input logic lg, input int n);
      int c;
      @(posedge mclk) req_valid <= 1'b1;
      req_long <= lg;
      c = 0;
      do @(negedge mclk); while (req_ready !== 1'b1 && ++c < 100);
      @(posedge mclk) req_valid <= 1'b0;
      c = 0;
      while (lnk.cmd !== (lg ? 3'h1 : 3'h2) && c < 20)
      begin
         @(negedge mclk);
         c++;
      end
      chk("zq command", lg ? 12'h001 : 12'h002, lnk.cmd);
      c = 0;
      while (cal_done !== 1'b1 && c < n + 10)
      begin
         @(negedge mclk);
         c++;
         if (c == n / 2)
         begin
            chk("zq path on", 12'h001, zq_path_on);
            chk("cal_busy", 12'h001, cal_busy);
            chk("cal_active", 12'h001, cal_active);
            chk("req_ready busy", 12'h000, req_ready);
         end
      end
      chk("interval", 12'h001, c >= n && c <= n + 2);
      chk("cal_active end", 12'h000, cal_active);
      n_cal++;
      c = 0;
      while (io_updated !== 1'b1 && c < 10)
      begin
         @(negedge mclk);
         c++;
      end
      chk("io_updated", 12'h001, io_updated);
      chk("io_cal_count", n_cal, io_cal_count);
      repeat (3) @(negedge mclk);
      chk("zq path off", 12'h000, zq_path_on);
      $display("calibration test done");
   endtask : cal
   task self_refresh;
      int c;
      @(posedge mclk) sr_enter <= 1'b1;
      c = 0;
      do @(negedge mclk); while (lnk.cke !== 1'b0 && ++c < 20);
      @(posedge mclk) sr_enter <= 1'b0;
      chk("cke in self refresh", 12'h000, lnk.cke);
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      chk("in_self_refresh", 12'h001, in_self_refresh);
      @(posedge mclk) sr_exit <= 1'b1;
      c = 0;
      do @(negedge mclk); while (lnk.cke !== 1'b1 && ++c < 20);
      @(posedge mclk) sr_exit <= 1'b0;
      c = 0;
      do @(negedge mclk); while (req_ready !== 1'b1 && ++c < 100);
      chk("txs wait", 12'h001, c >= dzq_pkg::T_XS_CYC - 2);
      chk("no recal on exit", n_cal, io_cal_count);
      chk("self refresh left", 12'h000, in_self_refresh);
      cal(1'b0, dzq_pkg::T_ZQCS_NCK);
      $display("self refresh test done");
   endtask : self_refresh
   initial
   begin
      repeat (8000) @(posedge mclk);
      n_errors++;
      $display("unexpected run length: expected end seen timeout");
      end_sim();
   end
   initial
   begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      req_valid = 1'b0;
      req_long = 1'b0;
      sr_enter = 1'b0;
      sr_exit = 1'b0;
      n_errors = 0;
      compares = 0;
      do_reset(10);
      cal(1'b1, dzq_pkg::T_ZQINIT_NCK);
      chk("init_done", 12'h001, init_done);
      cal(1'b1, dzq_pkg::T_ZQOPER_NCK);
      cal(1'b0, dzq_pkg::T_ZQCS_NCK);
      self_refresh();
      do_reset(2);
      cal(1'b1, dzq_pkg::T_ZQINIT_NCK);
      end_sim();
   end
endmodule : dzq_bench
